/* File: inc/stack_unit_pkg.sv */
// Constants and types shared by the stack and call/return unit.
// Function
// - Step pointer by two or four bytes
// - Selector push aligns pointer to two or four bytes
// - No alignment check, no fault raised
// - 16-bit attribute uses low pointer, wraps FFFFH
// - Stack width flag selects 16 or 32
// - Operand size from code flag, prefix toggles
// - Frame base references use stack segment
// - Near call pushes pointer, jumps to target
// - Near return pops pointer, releases n bytes
// - Far call pushes selector then pointer
// - Far return pops pointer, selector, releases n
// - Popped return address accepted unchecked
// - Long mode stack segment base is zero
// - Long mode forces privilege field to current
// - Long mode widens pointers to 64 bits
// - Long mode steps eight bytes, aligns selectors
// - Long mode rejects some segment load forms
// - Push decrements first; pop reads first
package stack_unit_pkg;
  localparam int ADDR_W = 64;
  localparam int SEL_W = 16;
  localparam logic [ADDR_W-1:0] TOP16 = 64'h0000_0000_0000_ffff;
  localparam logic [ADDR_W-1:0] TOP32 = 64'h0000_0000_ffff_ffff;
  localparam logic [3:0] STEP16 = 4'h2;
  localparam logic [3:0] STEP32 = 4'h4;
  localparam logic [3:0] STEP64 = 4'h8;
  localparam logic [1:0] WID16 = 2'h0;
  localparam logic [1:0] WID32 = 2'h1;
  localparam logic [1:0] WID64 = 2'h2;
  localparam logic [ADDR_W-1:0] SP_RESET = 64'h0000_0000_0000_0000;
  localparam logic [ADDR_W-1:0] IP_RESET = 64'h0000_0000_0000_0000;
  localparam logic [SEL_W-1:0] CS_RESET = 16'h0000;
  // Register bus offsets.
  localparam logic [3:0] OFS_SP = 4'h0;
  localparam logic [3:0] OFS_IP = 4'h1;
  localparam logic [3:0] OFS_FP = 4'h2;
  localparam logic [3:0] OFS_CS = 4'h3;
  localparam logic [3:0] OFS_CFG = 4'h4;
  localparam logic [3:0] OFS_SSBASE = 4'h5;
  localparam logic [3:0] OFS_STAT = 4'h6;
  localparam logic [3:0] OFS_EXPL = 4'h7;
  // Config field positions.
  localparam int CFG_CODE_D = 0;
  localparam int CFG_SS_B = 1;
  localparam int CFG_LONG = 2;
  localparam int CFG_CPL_LO = 3;
  localparam int CFG_CPL_HI = 4;
  localparam int CFG_DPL_LO = 5;
  localparam int CFG_DPL_HI = 6;
  // Operation codes.
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_PUSH = 4'h1, OP_POP = 4'h2, OP_PUSH_SEL = 4'h3,
    OP_CALL_NEAR = 4'h4, OP_RET_NEAR = 4'h5, OP_CALL_FAR = 4'h6, OP_RET_FAR = 4'h7,
    OP_LOAD_FAR_DS = 4'h8, OP_POP_EXTRA_SEGMENT = 4'h9
  } op_t;
  // Gray-coded sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_W1 = 3'b001, ST_W2 = 3'b011, ST_R1 = 3'b010,
    ST_R2 = 3'b110, ST_DONE = 3'b111
  } state_t;
endpackage : stack_unit_pkg

/* File: hw/stack_step.sv */
`timescale 1ns/1ps
// Stack width selection and pointer step arithmetic.
module stack_step (
  // Mode
  input wire logic [1:0] width,
  input wire logic sel_push,
  // Pointer
  input wire logic [stack_unit_pkg::ADDR_W-1:0] sp,
  input wire logic dir_down,
  output logic [stack_unit_pkg::ADDR_W-1:0] sp_new
);
  logic [stack_unit_pkg::ADDR_W-1:0] step;
  logic [stack_unit_pkg::ADDR_W-1:0] raw;
  logic [stack_unit_pkg::ADDR_W-1:0] aligned;
  always_comb begin
    case (width)
      stack_unit_pkg::WID16: step = {60'h0, stack_unit_pkg::STEP16};
      stack_unit_pkg::WID32: step = {60'h0, stack_unit_pkg::STEP32};
      default: step = {60'h0, stack_unit_pkg::STEP64};
    endcase
    // Misaligned pointers step as they are; nothing faults.
    raw = dir_down ? sp - step : sp + step;
    aligned = raw;
    // A selector push lands on the next boundary below of the stack width.
    if (sel_push && dir_down) begin
      aligned = raw & ~(step - 64'h1);
    end
    case (width)
      stack_unit_pkg::WID16: sp_new = aligned & stack_unit_pkg::TOP16;
      stack_unit_pkg::WID32: sp_new = aligned & stack_unit_pkg::TOP32;
      default: sp_new = aligned;
    endcase
  end
endmodule : stack_step

/* File: hw/stack_addr_gen.sv */
`timescale 1ns/1ps
// Linear stack address from segment base and offset.
module stack_addr_gen (
  // Mode
  input wire logic long_mode,
  input wire logic [1:0] width,
  // Address parts
  input wire logic [stack_unit_pkg::ADDR_W-1:0] seg_base,
  input wire logic [stack_unit_pkg::ADDR_W-1:0] offset,
  output logic [stack_unit_pkg::ADDR_W-1:0] lin_addr
);
  logic [stack_unit_pkg::ADDR_W-1:0] ofs;
  always_comb begin
    ofs = offset;
    if (width == stack_unit_pkg::WID16) begin
      ofs = offset & stack_unit_pkg::TOP16;
    end else if (width == stack_unit_pkg::WID32) begin
      ofs = offset & stack_unit_pkg::TOP32;
    end
    lin_addr = long_mode ? ofs : seg_base + ofs;
  end
endmodule : stack_addr_gen

/* File: hw/stack_call_return_unit.sv */
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Stack pointer control and call/return sequencer with a register port.
module stack_call_return_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rdata,
  // Operation request
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [63:0] op_data,
  input wire logic [15:0] op_sel,
  input wire logic [63:0] op_next_ip,
  input wire logic [15:0] op_release,
  input wire logic op_fp_based,
  input wire logic op_addr_prefix,
  output logic op_busy,
  output logic op_done,
  output logic op_invalid,
  output logic [63:0] pop_data,
  // Stack memory
  output logic mem_wr,
  output logic mem_rd,
  output logic [63:0] mem_addr,
  output logic [63:0] mem_wdata,
  input wire logic [63:0] mem_rdata
);
  localparam int AW = stack_unit_pkg::ADDR_W;

  logic [AW-1:0] sp_r, sp_nxt, ip_r, ip_nxt, fp_r, fp_nxt, base_r, base_nxt;
  logic [15:0] cs_r, cs_nxt;
  logic [6:0] cfg_r, cfg_nxt;
  logic [63:0] rdata_r, rdata_nxt;
  logic expl32_r, expl32_nxt;
  stack_unit_pkg::state_t st_r, st_nxt;
  stack_unit_pkg::op_t op_r, op_nxt;
  logic [AW-1:0] tgt_r, tgt_nxt, ret_r, ret_nxt;
  logic [15:0] tsel_r, tsel_nxt, rel_r, rel_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, inv_r, inv_nxt;
  logic [63:0] pdata_r, pdata_nxt;
  logic mwr_r, mwr_nxt, mrd_r, mrd_nxt;
  logic [63:0] maddr_r, maddr_nxt, mwdata_r, mwdata_nxt;
  logic rd_pend_r, rd_pend_nxt;

  logic long_mode;
  logic [1:0] width;
  logic [1:0] asz;
  logic [AW-1:0] sp_dn, sp_dn_sel, sp_up, lin_sp, lin_dn, lin_dn_sel, lin_fp, rel_ext;
  logic [1:0] current_privilege_level;

  assign long_mode = cfg_r[stack_unit_pkg::CFG_LONG];
  assign current_privilege_level = cfg_r[stack_unit_pkg::CFG_CPL_HI:stack_unit_pkg::CFG_CPL_LO];
  // Long mode overrides the descriptor width; otherwise the code size flag picks it.
  assign width = long_mode ? stack_unit_pkg::WID64 :
                 (cfg_r[stack_unit_pkg::CFG_CODE_D] ? stack_unit_pkg::WID32 : stack_unit_pkg::WID16);
  // Stack accesses take their address size from the stack descriptor flag, not from the code size flag.
  assign asz = long_mode ? stack_unit_pkg::WID64 :
               (cfg_r[stack_unit_pkg::CFG_SS_B] ? stack_unit_pkg::WID32 : stack_unit_pkg::WID16);
  assign rel_ext = {48'h0, rel_r};

  stack_step u_dn (
    .width(width),
    .sel_push(1'b0),
    .sp(sp_r),
    .dir_down(1'b1),
    .sp_new(sp_dn)
  );
  stack_step u_dn_sel (
    .width(width),
    .sel_push(1'b1),
    .sp(sp_r),
    .dir_down(1'b1),
    .sp_new(sp_dn_sel)
  );
  stack_step u_up (
    .width(width),
    .sel_push(1'b0),
    .sp(sp_r),
    .dir_down(1'b0),
    .sp_new(sp_up)
  );
  stack_addr_gen u_a_sp (
    .long_mode(long_mode),
    .width(asz),
    .seg_base(base_r),
    .offset(sp_r),
    .lin_addr(lin_sp)
  );
  stack_addr_gen u_a_dn (
    .long_mode(long_mode),
    .width(asz),
    .seg_base(base_r),
    .offset(sp_dn),
    .lin_addr(lin_dn)
  );
  stack_addr_gen u_a_dns (
    .long_mode(long_mode),
    .width(asz),
    .seg_base(base_r),
    .offset(sp_dn_sel),
    .lin_addr(lin_dn_sel)
  );
  // Frame base references go through the same stack segment.
  stack_addr_gen u_a_fp (
    .long_mode(long_mode),
    .width(asz),
    .seg_base(base_r),
    .offset(fp_r),
    .lin_addr(lin_fp)
  );

  always_comb begin
    sp_nxt = sp_r;
    ip_nxt = ip_r;
    fp_nxt = fp_r;
    base_nxt = base_r;
    cs_nxt = cs_r;
    cfg_nxt = cfg_r;
    expl32_nxt = expl32_r;
    st_nxt = st_r;
    op_nxt = op_r;
    tgt_nxt = tgt_r;
    ret_nxt = ret_r;
    tsel_nxt = tsel_r;
    rel_nxt = rel_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    inv_nxt = 1'b0;
    pdata_nxt = pdata_r;
    mwr_nxt = 1'b0;
    mrd_nxt = 1'b0;
    maddr_nxt = maddr_r;
    mwdata_nxt = mwdata_r;
    rd_pend_nxt = 1'b0;
    rdata_nxt = 64'h0;
    // Explicit operand size: code flag, flipped by the address-size prefix.
    if (op_valid) begin
      expl32_nxt = cfg_r[stack_unit_pkg::CFG_CODE_D] ^ op_addr_prefix;
    end
    if (reg_wr && !busy_r) begin
      case (reg_addr)
        stack_unit_pkg::OFS_SP: sp_nxt = reg_wdata;
        stack_unit_pkg::OFS_IP: ip_nxt = reg_wdata;
        stack_unit_pkg::OFS_FP: fp_nxt = reg_wdata;
        stack_unit_pkg::OFS_CS: cs_nxt = reg_wdata[15:0];
        stack_unit_pkg::OFS_CFG: cfg_nxt = reg_wdata[6:0];
        stack_unit_pkg::OFS_SSBASE: base_nxt = reg_wdata;
        default: ;
      endcase
    end
    // Privilege field tracks the current level in long mode, even on its own write.
    if (cfg_nxt[stack_unit_pkg::CFG_LONG]) begin
      cfg_nxt[stack_unit_pkg::CFG_DPL_HI:stack_unit_pkg::CFG_DPL_LO] =
        cfg_nxt[stack_unit_pkg::CFG_CPL_HI:stack_unit_pkg::CFG_CPL_LO];
    end
    if (reg_rd) begin
      case (reg_addr)
        stack_unit_pkg::OFS_SP: rdata_nxt = sp_r;
        stack_unit_pkg::OFS_IP: rdata_nxt = ip_r;
        stack_unit_pkg::OFS_FP: rdata_nxt = lin_fp;
        stack_unit_pkg::OFS_CS: rdata_nxt = {48'h0, cs_r};
        stack_unit_pkg::OFS_CFG: rdata_nxt = {57'h0, cfg_r};
        stack_unit_pkg::OFS_SSBASE: rdata_nxt = long_mode ? 64'h0 : base_r;
        stack_unit_pkg::OFS_STAT: rdata_nxt = {60'h0, busy_r, st_r};
        stack_unit_pkg::OFS_EXPL: rdata_nxt = {63'h0, expl32_r};
        default: rdata_nxt = 64'h0;
      endcase
    end
    case (st_r)
      stack_unit_pkg::ST_IDLE: begin
        if (op_valid) begin
          op_nxt = stack_unit_pkg::op_t'(op_code);
          tgt_nxt = op_data;
          tsel_nxt = op_sel;
          rel_nxt = op_release;
          ret_nxt = op_next_ip;
          busy_nxt = 1'b1;
          case (stack_unit_pkg::op_t'(op_code))
            stack_unit_pkg::OP_PUSH, stack_unit_pkg::OP_CALL_NEAR: begin
              // Decrement first, then write the new top.
              sp_nxt = sp_dn;
              maddr_nxt = lin_dn;
              mwdata_nxt = (op_code == stack_unit_pkg::OP_PUSH) ? op_data : op_next_ip;
              mwr_nxt = 1'b1;
              st_nxt = stack_unit_pkg::ST_DONE;
            end
            stack_unit_pkg::OP_PUSH_SEL, stack_unit_pkg::OP_CALL_FAR: begin
              // Selector goes first and keeps the pointer aligned.
              sp_nxt = sp_dn_sel;
              maddr_nxt = lin_dn_sel;
              mwdata_nxt = (op_code == stack_unit_pkg::OP_PUSH_SEL) ? {48'h0, op_data[15:0]} : {48'h0, cs_r};
              mwr_nxt = 1'b1;
              st_nxt = (op_code == stack_unit_pkg::OP_CALL_FAR) ? stack_unit_pkg::ST_W1 : stack_unit_pkg::ST_DONE;
            end
            stack_unit_pkg::OP_POP, stack_unit_pkg::OP_RET_NEAR, stack_unit_pkg::OP_RET_FAR: begin
              // Read the top first, step the pointer when the data returns.
              maddr_nxt = lin_sp;
              mrd_nxt = 1'b1;
              st_nxt = stack_unit_pkg::ST_R1;
            end
            stack_unit_pkg::OP_LOAD_FAR_DS, stack_unit_pkg::OP_POP_EXTRA_SEGMENT: begin
              inv_nxt = long_mode;
              done_nxt = 1'b1;
              busy_nxt = 1'b0;
              st_nxt = stack_unit_pkg::ST_IDLE;
            end
            default: begin
              done_nxt = 1'b1;
              busy_nxt = 1'b0;
            end
          endcase
        end
      end
      stack_unit_pkg::ST_W1: begin
        // Second push of a far call carries the return pointer.
        sp_nxt = sp_dn;
        maddr_nxt = lin_dn;
        mwdata_nxt = ret_r;
        mwr_nxt = 1'b1;
        st_nxt = stack_unit_pkg::ST_DONE;
      end
      stack_unit_pkg::ST_R1: begin
        sp_nxt = sp_up;
        pdata_nxt = mem_rdata;
        if (op_r == stack_unit_pkg::OP_RET_FAR) begin
          // Popped pointer is taken as is, without any range check.
          ip_nxt = mem_rdata;
          st_nxt = stack_unit_pkg::ST_R2;
          rd_pend_nxt = 1'b1;
        end else begin
          if (op_r == stack_unit_pkg::OP_RET_NEAR) begin
            ip_nxt = mem_rdata;
            sp_nxt = sp_up + rel_ext;
          end
          st_nxt = stack_unit_pkg::ST_DONE;
        end
      end
      stack_unit_pkg::ST_R2: begin
        // Issue the selector read at the stepped pointer.
        if (rd_pend_r) begin
          maddr_nxt = lin_sp;
          mrd_nxt = 1'b1;
        end else begin
          cs_nxt = mem_rdata[15:0];
          sp_nxt = sp_up + rel_ext;
          st_nxt = stack_unit_pkg::ST_DONE;
        end
      end
      stack_unit_pkg::ST_DONE: begin
        if (op_r == stack_unit_pkg::OP_CALL_NEAR || op_r == stack_unit_pkg::OP_CALL_FAR) begin
          ip_nxt = tgt_r;
        end
        if (op_r == stack_unit_pkg::OP_CALL_FAR) begin
          cs_nxt = tsel_r;
        end
        done_nxt = 1'b1;
        busy_nxt = 1'b0;
        st_nxt = stack_unit_pkg::ST_IDLE;
      end
      default: st_nxt = stack_unit_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sp_r <= stack_unit_pkg::SP_RESET;
      ip_r <= stack_unit_pkg::IP_RESET;
      fp_r <= 64'h0;
      base_r <= 64'h0;
      cs_r <= stack_unit_pkg::CS_RESET;
      cfg_r <= 7'h0;
      expl32_r <= 1'b0;
      st_r <= stack_unit_pkg::ST_IDLE;
      op_r <= stack_unit_pkg::OP_NONE;
      tgt_r <= 64'h0;
      ret_r <= 64'h0;
      tsel_r <= 16'h0;
      rel_r <= 16'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      inv_r <= 1'b0;
      pdata_r <= 64'h0;
      mwr_r <= 1'b0;
      mrd_r <= 1'b0;
      maddr_r <= 64'h0;
      mwdata_r <= 64'h0;
      rd_pend_r <= 1'b0;
      rdata_r <= 64'h0;
    end else begin
      sp_r <= sp_nxt;
      ip_r <= ip_nxt;
      fp_r <= fp_nxt;
      base_r <= base_nxt;
      cs_r <= cs_nxt;
      cfg_r <= cfg_nxt;
      expl32_r <= expl32_nxt;
      st_r <= st_nxt;
      op_r <= op_nxt;
      tgt_r <= tgt_nxt;
      ret_r <= ret_nxt;
      tsel_r <= tsel_nxt;
      rel_r <= rel_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      inv_r <= inv_nxt;
      pdata_r <= pdata_nxt;
      mwr_r <= mwr_nxt;
      mrd_r <= mrd_nxt;
      maddr_r <= maddr_nxt;
      mwdata_r <= mwdata_nxt;
      rd_pend_r <= rd_pend_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign op_busy = busy_r;
  assign op_done = done_r;
  assign op_invalid = inv_r;
  assign pop_data = pdata_r;
  assign mem_wr = mwr_r;
  assign mem_rd = mrd_r;
  assign mem_addr = maddr_r;
  assign mem_wdata = mwdata_r;

  a_push_step: assert property (@(posedge clk) disable iff (rst)
    (st_r == stack_unit_pkg::ST_IDLE && op_valid && op_code == stack_unit_pkg::OP_PUSH && width == stack_unit_pkg::WID32)
    |=> (sp_r == (($past(sp_r) - 64'h4) & stack_unit_pkg::TOP32)))
    else $error("push did not step pointer by four");
  a_long_step: assert property (@(posedge clk) disable iff (rst)
    (st_r == stack_unit_pkg::ST_IDLE && op_valid && op_code == stack_unit_pkg::OP_PUSH && long_mode)
    |=> (sp_r == $past(sp_r) - 64'h8))
    else $error("long push did not step by eight");
  a_sel_align: assert property (@(posedge clk) disable iff (rst)
    (st_r == stack_unit_pkg::ST_IDLE && op_valid && op_code == stack_unit_pkg::OP_PUSH_SEL && width == stack_unit_pkg::WID32)
    |=> (sp_r[1:0] == 2'h0))
    else $error("selector push left pointer unaligned");
  a_push_write: assert property (@(posedge clk) disable iff (rst)
    (st_r == stack_unit_pkg::ST_IDLE && op_valid && op_code == stack_unit_pkg::OP_PUSH && long_mode)
    |=> (mem_wr && mem_addr == sp_r))
    else $error("push wrote before decrementing");
  a_dpl_force: assert property (@(posedge clk) disable iff (rst)
    long_mode |-> (cfg_r[stack_unit_pkg::CFG_DPL_HI:stack_unit_pkg::CFG_DPL_LO] == current_privilege_level))
    else $error("privilege field differs from current level");
  a_long_invalid: assert property (@(posedge clk) disable iff (rst)
    (st_r == stack_unit_pkg::ST_IDLE && op_valid && op_code == stack_unit_pkg::OP_POP_EXTRA_SEGMENT && long_mode)
    |=> (op_invalid && op_done))
    else $error("segment pop not rejected in long mode");
  sequence s_near_call_start;
    st_r == stack_unit_pkg::ST_IDLE && op_valid && op_code == stack_unit_pkg::OP_CALL_NEAR;
  endsequence
  a_near_call: assert property (@(posedge clk) disable iff (rst)
    s_near_call_start |=> (mem_wr && mem_wdata == $past(op_next_ip)) ##1 (ip_r == $past(tgt_r) && op_done))
    else $error("near call sequence wrong");
  a_near_ret: assert property (@(posedge clk) disable iff (rst)
    (st_r == stack_unit_pkg::ST_R1 && op_r == stack_unit_pkg::OP_RET_NEAR)
    |=> (ip_r == $past(mem_rdata) && sp_r == $past(sp_up) + $past(rel_ext)))
    else $error("near return pop or release wrong");
  a_far_call: assert property (@(posedge clk) disable iff (rst)
    (st_r == stack_unit_pkg::ST_IDLE && op_valid && op_code == stack_unit_pkg::OP_CALL_FAR)
    |=> (mem_wdata == {48'h0, $past(cs_r)}) ##1 (mem_wdata == ret_r) ##2 (cs_r == tsel_r))
    else $error("far call push order wrong");
endmodule : stack_call_return_unit

/* File: sim/stack_mem_model.sv */
`timescale 1ns/1ps
// Behavioural stack memory that answers while each read strobe stands.
module stack_mem_model (
  // Clock
  input wire logic clk,
  // Requests from the unit
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [63:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  // Answer
  output logic [63:0] mem_rdata
);
  logic [63:0] store [logic [63:0]];
  logic [63:0] wr_addr_q [$];
  logic [63:0] wr_data_q [$];
  logic [63:0] rd_word;

  initial begin
    rd_word = 64'h0;
  end

  // The unit captures the word at the edge that closes its read cycle, so it is driven while mem_rd stands.
  // Outside that cycle the bus shows the inverse of the last word, so a stray capture cannot match by luck.
  always @* begin
    if (mem_rd) begin
      mem_rdata = store.exists(mem_addr) ? store[mem_addr] : 64'h0;
    end else begin
      mem_rdata = ~rd_word;
    end
  end

  always @(posedge clk) begin
    if (mem_rd) begin
      rd_word <= store.exists(mem_addr) ? store[mem_addr] : 64'h0;
    end
    if (mem_wr) begin
      store[mem_addr] = mem_wdata;
      wr_addr_q.push_back(mem_addr);
      wr_data_q.push_back(mem_wdata);
    end
  end
endmodule : stack_mem_model

/* File: sim/stack_call_return_unit_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the stack and call/return unit.
module stack_call_return_unit_tb;
  logic clk;
  logic rst;
  logic [3:0] reg_addr;
  logic [63:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [63:0] reg_rdata;
  logic op_valid;
  logic [3:0] op_code;
  logic [63:0] op_data;
  logic [15:0] op_sel;
  logic [63:0] op_next_ip;
  logic [15:0] op_release;
  logic op_fp_based;
  logic op_addr_prefix;
  logic op_busy;
  logic op_done;
  logic op_invalid;
  logic [63:0] pop_data;
  logic mem_wr;
  logic mem_rd;
  logic [63:0] mem_addr;
  logic [63:0] mem_wdata;
  logic [63:0] mem_rdata;
  logic seen_invalid;
  int fail_count;
  int checks_done;
  int i;

  stack_call_return_unit u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code), .op_data(op_data), .op_sel(op_sel),
    .op_next_ip(op_next_ip), .op_release(op_release), .op_fp_based(op_fp_based),
    .op_addr_prefix(op_addr_prefix), .op_busy(op_busy), .op_done(op_done), .op_invalid(op_invalid),
    .pop_data(pop_data), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
  );

  stack_mem_model u_mem (
    .clk(clk), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic reg_write(input logic [3:0] a, input logic [63:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic chk_reg(input string n, input logic [3:0] a, input logic [63:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask : chk_reg

  task automatic do_op(input logic [3:0] c, input logic [63:0] d, input logic [15:0] s,
                       input logic [63:0] nip, input logic [15:0] n, input logic pfx);
    int k;
    u_mem.wr_addr_q.delete();
    u_mem.wr_data_q.delete();
    @(posedge clk);
    op_code <= c;
    op_data <= d;
    op_sel <= s;
    op_next_ip <= nip;
    op_release <= n;
    op_addr_prefix <= pfx;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    for (k = 0; k < 20; k++) begin
      #1;
      if (op_done === 1'b1) break;
      @(posedge clk);
    end
    chk("op done", 64'h1, {63'h0, op_done});
    seen_invalid = op_invalid;
  endtask : do_op

  // Writes are checked in issue order, which is how push order shows.
  task automatic chk_wr(input logic [63:0] a, input logic [63:0] d);
    if (u_mem.wr_addr_q.size() == 0) begin
      chk("write present", 64'h1, 64'h0);
    end else begin
      chk("write addr", a, u_mem.wr_addr_q.pop_front());
      chk("write data", d, u_mem.wr_data_q.pop_front());
    end
  endtask : chk_wr

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 64'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    op_valid = 1'b0;
    op_code = 4'h0;
    op_data = 64'h0;
    op_sel = 16'h0;
    op_next_ip = 64'h0;
    op_release = 16'h0;
    op_fp_based = 1'b1;
    op_addr_prefix = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk_reg("sp reset", stack_unit_pkg::OFS_SP, 64'h0);
    chk_reg("unmapped", 4'h8, 64'h0);
    // A 16-bit stack wraps below zero to the top of its 64 KiB space.
    reg_write(stack_unit_pkg::OFS_SSBASE, 64'h0);
    reg_write(stack_unit_pkg::OFS_CFG, 64'h0);
    do_op(stack_unit_pkg::OP_PUSH, 64'habcd, 16'h0, 64'h0, 16'h0, 1'b0);
    chk_wr(64'hfffe, 64'habcd);
    chk_reg("sp16 push", stack_unit_pkg::OFS_SP, 64'hfffe);
    do_op(stack_unit_pkg::OP_POP, 64'h0, 16'h0, 64'h0, 16'h0, 1'b0);
    chk("pop16 data", 64'habcd, pop_data);
    chk_reg("sp16 pop", stack_unit_pkg::OFS_SP, 64'h0);
    for (i = 0; i < 4; i++) begin
      reg_write(stack_unit_pkg::OFS_CFG, {63'h0, i[1]});
      do_op(stack_unit_pkg::OP_PUSH, 64'h1, 16'h0, 64'h0, 16'h0, i[0]);
      chk_reg("explicit size", stack_unit_pkg::OFS_EXPL, {63'h0, i[1] ^ i[0]});
    end
    // Code size flag set, stack flag clear: four-byte steps, but accesses use the 16-bit pointer.
    reg_write(stack_unit_pkg::OFS_CFG, 64'h1);
    reg_write(stack_unit_pkg::OFS_SP, 64'h1_0008);
    do_op(stack_unit_pkg::OP_PUSH, 64'h66, 16'h0, 64'h0, 16'h0, 1'b0);
    chk_wr(64'h4, 64'h66);
    reg_write(stack_unit_pkg::OFS_CFG, 64'h3);
    chk_reg("cfg flags", stack_unit_pkg::OFS_CFG, 64'h3);
    reg_write(stack_unit_pkg::OFS_SP, 64'h100);
    do_op(stack_unit_pkg::OP_PUSH, 64'h1234_5678, 16'h0, 64'h0, 16'h0, 1'b0);
    chk_wr(64'hfc, 64'h1234_5678);
    reg_write(stack_unit_pkg::OFS_SP, 64'h102);
    do_op(stack_unit_pkg::OP_PUSH_SEL, 64'h0023, 16'h0, 64'h0, 16'h0, 1'b0);
    chk("misaligned accepted", 64'h0, {63'h0, seen_invalid});
    chk_wr(64'hfc, 64'h23);
    chk_reg("sp sel align", stack_unit_pkg::OFS_SP, 64'hfc);
    do_op(stack_unit_pkg::OP_POP, 64'h0, 16'h0, 64'h0, 16'h0, 1'b0);
    chk("pop32 data", 64'h23, pop_data);
    chk_reg("sp32 pop", stack_unit_pkg::OFS_SP, 64'h100);
    // Near call and return, then one with the saved address rewritten by software.
    reg_write(stack_unit_pkg::OFS_SP, 64'h200);
    do_op(stack_unit_pkg::OP_CALL_NEAR, 64'h4000, 16'h0, 64'h1234, 16'h0, 1'b0);
    chk_wr(64'h1fc, 64'h1234);
    chk_reg("ip near call", stack_unit_pkg::OFS_IP, 64'h4000);
    reg_write(stack_unit_pkg::OFS_FP, 64'h1fc);
    do_op(stack_unit_pkg::OP_RET_NEAR, 64'h0, 16'h0, 64'h0, 16'h8, 1'b0);
    chk_reg("ip near ret", stack_unit_pkg::OFS_IP, 64'h1234);
    chk_reg("sp near ret", stack_unit_pkg::OFS_SP, 64'h208);
    do_op(stack_unit_pkg::OP_CALL_NEAR, 64'h4000, 16'h0, 64'h1234, 16'h0, 1'b0);
    u_mem.store[64'h204] = 64'h9999;
    do_op(stack_unit_pkg::OP_RET_NEAR, 64'h0, 16'h0, 64'h0, 16'h0, 1'b0);
    chk_reg("ip altered ret", stack_unit_pkg::OFS_IP, 64'h9999);
    // Far call pushes the selector first; far return pops it last.
    reg_write(stack_unit_pkg::OFS_CS, 64'h8);
    reg_write(stack_unit_pkg::OFS_SP, 64'h300);
    do_op(stack_unit_pkg::OP_CALL_FAR, 64'h8000, 16'h0010, 64'h42, 16'h0, 1'b0);
    chk_wr(64'h2fc, 64'h8);
    chk_wr(64'h2f8, 64'h42);
    chk_reg("cs far call", stack_unit_pkg::OFS_CS, 64'h10);
    chk_reg("ip far call", stack_unit_pkg::OFS_IP, 64'h8000);
    do_op(stack_unit_pkg::OP_RET_FAR, 64'h0, 16'h0, 64'h0, 16'h4, 1'b0);
    chk_reg("ip far ret", stack_unit_pkg::OFS_IP, 64'h42);
    chk_reg("cs far ret", stack_unit_pkg::OFS_CS, 64'h8);
    chk_reg("sp far ret", stack_unit_pkg::OFS_SP, 64'h304);
    // Frame base and stack traffic both go through the stack segment base.
    reg_write(stack_unit_pkg::OFS_SSBASE, 64'h1000);
    reg_write(stack_unit_pkg::OFS_FP, 64'h20);
    chk_reg("frame linear", stack_unit_pkg::OFS_FP, 64'h1020);
    reg_write(stack_unit_pkg::OFS_SP, 64'h100);
    do_op(stack_unit_pkg::OP_PUSH, 64'h5, 16'h0, 64'h0, 16'h0, 1'b0);
    chk_wr(64'h10fc, 64'h5);
    // Long mode: base ignored, privilege field follows the current level, eight-byte steps.
    reg_write(stack_unit_pkg::OFS_CFG, 64'h1c);
    chk_reg("dpl forced", stack_unit_pkg::OFS_CFG, 64'h7c);
    chk_reg("ss base long", stack_unit_pkg::OFS_SSBASE, 64'h0);
    reg_write(stack_unit_pkg::OFS_SP, 64'h1_0000_0000_0010);
    do_op(stack_unit_pkg::OP_PUSH, 64'h77, 16'h0, 64'h0, 16'h0, 1'b0);
    chk_wr(64'h1_0000_0000_0008, 64'h77);
    reg_write(stack_unit_pkg::OFS_SP, 64'h104);
    do_op(stack_unit_pkg::OP_PUSH_SEL, 64'h0031, 16'h0, 64'h0, 16'h0, 1'b0);
    chk_reg("sp64 sel align", stack_unit_pkg::OFS_SP, 64'hf8);
    for (i = 0; i < 2; i++) begin
      do_op(i ? stack_unit_pkg::OP_POP_EXTRA_SEGMENT : stack_unit_pkg::OP_LOAD_FAR_DS, 64'h0, 16'h0, 64'h0, 16'h0, 1'b0);
      chk("invalid form", 64'h1, {63'h0, seen_invalid});
      chk_reg("sp after invalid", stack_unit_pkg::OFS_SP, 64'hf8);
    end
    conclude();
  end
endmodule : stack_call_return_unit_tb
